// >>> design/pwm_output_steering.sv
/*
  PWM output steering stage in single-output mode: one modulated signal
  routed to any of four pins with polarity per pin pair (A/C, B/D) and auto-shutdown.
  Assumes a plain register port with one-cycle strobes, read data one
  cycle later, and a synchronous shutdown input.
*/
`timescale 1ns/1ps
`include "steer_defs.svh"
module pwm_output_steering
  import steer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire addr_t reg_addr,
  input wire byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output byte_t reg_rdata,
  input wire logic shutdown_in,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output pins_t pin_oe
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  byte_t pwm_unit_control_reg_q;
  byte_t steering_control_reg_q;
  byte_t period_q;
  byte_t duty_q;
  byte_t port_latch_q;
  byte_t pin_direction_bits_q;
  byte_t shutdown_ctrl_q;
  pins_t steer_active_q;
  pins_t steer_active_d;
  logic steer_pending_q;
  byte_t reg_rdata_q;
  pins_t pin_level_q;
  pins_t pin_oe_q;

  logic [1:0] pwm_mode_upper_bits;
  logic [1:0] pwm_polarity_bits;
  logic [1:0] output_config_select;
  pins_t steer_enable;
  logic steering_sync_select;
  logic steering_mode;
  logic period_start;
  logic pwm_raw;
  logic shutdown_active;
  logic steer_write;
  logic shutdown_clear;

  function automatic logic hit(input addr_t a, input addr_t target);
    hit = (a == target);
  endfunction

  assign pwm_mode_upper_bits =
    pwm_unit_control_reg_q[`MODE_UPPER_LSB +: 2];
  assign pwm_polarity_bits = pwm_unit_control_reg_q[`POLARITY_LSB +: 2];
  assign output_config_select =
    pwm_unit_control_reg_q[`OUTPUT_CONFIG_LSB +: 2];
  assign steer_enable = steering_control_reg_q[`STEER_EN_LSB +: 4];
  assign steering_sync_select = steering_control_reg_q[`STEER_SYNC_BIT];

  // Both fields must match before the pins are taken over
  assign steering_mode = (pwm_mode_upper_bits == `MODE_UPPER_PWM) &&
    (output_config_select == `OUTPUT_CONFIG_SINGLE);

  assign steer_write = reg_write &&
    hit(reg_addr, `STEERING_CONTROL_REG_ADDR);
  assign shutdown_clear = reg_write &&
    hit(reg_addr, `SHUTDOWN_CTRL_REG_ADDR) &&
    !reg_wdata[`SHUTDOWN_EVENT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_unit_control_reg_q <= `UNIT_CONTROL_RESET;
      steering_control_reg_q <= `STEERING_CONTROL_RESET;
      period_q <= `PERIOD_RESET;
      duty_q <= `DUTY_RESET;
      port_latch_q <= `PORT_LATCH_RESET;
      pin_direction_bits_q <= `PIN_DIRECTION_RESET;
    end else if (reg_write) begin
      unique case (reg_addr)
        `PWM_UNIT_CONTROL_REG_ADDR: pwm_unit_control_reg_q <= reg_wdata;
        `STEERING_CONTROL_REG_ADDR: begin
          steering_control_reg_q <= {3'h0, reg_wdata[4:0]};
        end
        `PWM_PERIOD_REG_ADDR: period_q <= reg_wdata;
        `PWM_DUTY_REG_ADDR: duty_q <= reg_wdata;
        `PORT_LATCH_REG_ADDR: port_latch_q <= {4'h0, reg_wdata[3:0]};
        `PIN_DIRECTION_REG_ADDR: begin
          pin_direction_bits_q <= {4'h0, reg_wdata[3:0]};
        end
        default: begin
        end
      endcase
    end
  end

  // Event bit is hardware-set; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_ctrl_q <= `SHUTDOWN_CTRL_RESET;
    end else begin
      if (reg_write && hit(reg_addr, `SHUTDOWN_CTRL_REG_ADDR)) begin
        shutdown_ctrl_q[7:1] <= {4'h0, reg_wdata[3:1]};
      end
      shutdown_ctrl_q[`SHUTDOWN_EVENT_BIT] <= shutdown_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Time base and shutdown

  pwm_timebase u_timebase (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .run(steering_mode),
    .period(period_q),
    .duty(duty_q),
    .period_start(period_start),
    .pwm_raw(pwm_raw)
  );

  steer_shutdown u_shutdown (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .shutdown_event(shutdown_in),
    .auto_restart(shutdown_ctrl_q[`SHUTDOWN_RESTART_BIT]),
    .sw_clear(shutdown_clear),
    .period_start(period_start),
    .shutdown_active(shutdown_active)
  );

  ////////////////////////////////////////////////////////////////////////
  // Effective steering selection

  // Immediate mode may cut a pulse short; synced mode never does
  always_comb begin
    steer_active_d = steer_active_q;
    if (!steering_sync_select) begin
      steer_active_d = steer_enable;
    end else if (period_start && steer_pending_q) begin
      steer_active_d = steer_enable;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      steer_active_q <= 4'h0;
    end else begin
      steer_active_q <= steer_active_d;
    end
  end

  // A write during the start cycle stays pending for the next period
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      steer_pending_q <= 1'b0;
    end else if (steer_write) begin
      steer_pending_q <= 1'b1;
    end else if (period_start) begin
      steer_pending_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_level_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (steering_mode && steer_active_d[i]) begin
          // Polarity: bit 0 sets A/C, bit 1 sets B/D active level
          if (shutdown_active) begin
            pin_level_q[i] <= i[0] ?
              shutdown_ctrl_q[`SHUTDOWN_LEVEL_BD_BIT] :
              shutdown_ctrl_q[`SHUTDOWN_LEVEL_AC_BIT];
          end else begin
            pin_level_q[i] <= pwm_raw ^
              (i[0] ? pwm_polarity_bits[1] :
               pwm_polarity_bits[0]);
          end
        end else begin
          pin_level_q[i] <= port_latch_q[i];
        end
      end
    end
  end

  // Driver on only where direction bit is 0
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe_q <= 4'h0;
    end else begin
      pin_oe_q <= ~pin_direction_bits_q[3:0];
    end
  end

  assign pwm_out_a = pin_level_q[0];
  assign pwm_out_b = pin_level_q[1];
  assign pwm_out_c = pin_level_q[2];
  assign pwm_out_d = pin_level_q[3];
  assign pin_oe = pin_oe_q;

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `PWM_UNIT_CONTROL_REG_ADDR: reg_rdata_q <= pwm_unit_control_reg_q;
        `STEERING_CONTROL_REG_ADDR: reg_rdata_q <= steering_control_reg_q;
        `PWM_PERIOD_REG_ADDR: reg_rdata_q <= period_q;
        `PWM_DUTY_REG_ADDR: reg_rdata_q <= duty_q;
        `PORT_LATCH_REG_ADDR: reg_rdata_q <= port_latch_q;
        `PIN_DIRECTION_REG_ADDR: reg_rdata_q <= pin_direction_bits_q;
        `SHUTDOWN_CTRL_REG_ADDR: reg_rdata_q <= shutdown_ctrl_q;
        `STEER_STATUS_REG_ADDR: begin
          reg_rdata_q <= {2'h0, steering_mode, steer_pending_q,
            steer_active_q};
        end
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_q;
endmodule

// >>> design/pwm_timebase.sv
/*
  PWM time base: counts a period, raises a one-cycle period-start pulse
  and gives the raw modulated level (high while count below duty).
  Assumes period and duty come from registers in the clock domain.
*/
`timescale 1ns/1ps
module pwm_timebase
  import steer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic run,
  input wire byte_t period,
  input wire byte_t duty,
  output logic period_start,
  output logic pwm_raw
);
  byte_t count_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
    end else if (!run || count_q == period) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_q + 8'h01;
    end
  end

  // Start pulse aligns with the last count (count equals period), one cycle before count zero, so new settings see a whole period
  assign period_start = run && (count_q == period);
  assign pwm_raw = run && (count_q < duty);
endmodule

// >>> design/steer_defs.svh
/*
  Constants for the PWM output steering stage: register offsets, field
  positions and reset values.
  Assumes it is included by bare name from design files only.
*/
`ifndef STEER_DEFS_SVH
`define STEER_DEFS_SVH

// Register offsets on the plain register port
`define PWM_UNIT_CONTROL_REG_ADDR 4'h0
`define STEERING_CONTROL_REG_ADDR 4'h1
`define PWM_PERIOD_REG_ADDR 4'h2
`define PWM_DUTY_REG_ADDR 4'h3
`define PORT_LATCH_REG_ADDR 4'h4
`define PIN_DIRECTION_REG_ADDR 4'h5
`define SHUTDOWN_CTRL_REG_ADDR 4'h6
`define STEER_STATUS_REG_ADDR 4'h7

// Field positions in the unit control register
`define POLARITY_LSB 0
`define MODE_UPPER_LSB 2
`define OUTPUT_CONFIG_LSB 6

// Field positions in the steering control register
`define STEER_EN_LSB 0
`define STEER_SYNC_BIT 4

// Field positions in the shutdown control register
`define SHUTDOWN_EVENT_BIT 0
`define SHUTDOWN_RESTART_BIT 1
`define SHUTDOWN_LEVEL_AC_BIT 2
`define SHUTDOWN_LEVEL_BD_BIT 3

// Codes selecting single-output steering
`define MODE_UPPER_PWM 2'h3
`define OUTPUT_CONFIG_SINGLE 2'h0

// Reset values
`define UNIT_CONTROL_RESET 8'h00
`define STEERING_CONTROL_RESET 8'h01
`define PERIOD_RESET 8'hFF
`define DUTY_RESET 8'h00
`define PORT_LATCH_RESET 8'h00
`define PIN_DIRECTION_RESET 8'h0F
`define SHUTDOWN_CTRL_RESET 8'h00

`endif

// >>> design/steer_pkg.sv
/*
  Types shared by the PWM output steering stage.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package steer_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [3:0] pins_t;
  typedef logic [3:0] addr_t;
endpackage

// >>> design/steer_shutdown.sv
/*
  Auto-shutdown latch: a shutdown event sets a sticky state held until
  restart is allowed at a period start or software clears it.
  Assumes the event input is synchronous to sys_clk.
*/
`timescale 1ns/1ps
module steer_shutdown (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic shutdown_event,
  input wire logic auto_restart,
  input wire logic sw_clear,
  input wire logic period_start,
  output logic shutdown_active
);
  logic active_q;

  // Event wins over any clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else if (shutdown_event) begin
      active_q <= 1'b1;
    end else if (sw_clear || (auto_restart && period_start)) begin
      active_q <= 1'b0;
    end
  end

  assign shutdown_active = active_q || shutdown_event;
endmodule

// >>> tb/pin_load.sv
/*
  Load model: four switch inputs with pull-down resistors on the pins.
  Assumes the pin levels and output enables of the steering stage.
*/
`timescale 1ns/1ps
module pin_load
  import steer_pkg::*;
(
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire pins_t pin_oe,
  output pins_t pad
);
  // An undriven pin sinks to its pull-down, so a lost enable shows as 0
  assign pad = pin_oe & {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
endmodule

// >>> tb/pwm_output_steering_tb_top.sv
/*
  Bench top: table of steering cases, then shutdown and synchronised
  steering. Assumes the load model and the port checker.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %h got %h", n, e, g); end end
module pwm_output_steering_tb_top;
  import steer_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  addr_t reg_addr = 4'h0;
  byte_t reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic shutdown_in = 1'b0;
  byte_t reg_rdata;
  logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
  pins_t pin_oe, pad;
  int mismatches = 0;
  int checks_done = 0;
  logic [15:0] cnt;
  // Rows: control, steering, latch, then high counts per pin D..A
  logic [39:0] rows [6] = '{40'h0C01000002, 40'h0D0F002626,
    40'h0E0A056868, 40'h080F030088, 40'h4C0F0C8800, 40'h0F06000660};
  always #20 sys_clk = ~sys_clk;
  pwm_output_steering uut (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .shutdown_in, .pwm_out_a,
    .pwm_out_b, .pwm_out_c, .pwm_out_d, .pin_oe);
  pin_load load (.pwm_out_a, .pwm_out_b, .pwm_out_c, .pwm_out_d,
    .pin_oe, .pad);
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input addr_t a, input byte_t e, input string n);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask
  // Eight cycles span two whole periods of four, so phase does not matter
  task automatic count8(output logic [15:0] c);
    c = 16'h0000;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      for (int i = 0; i < 4; i++) c[i*4 +: 4] += 4'(pad[i]);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(4'h1, 8'h01, "steer reset");
    rd(4'h5, 8'h0F, "dir reset");
    rd(4'h9, 8'h00, "unmapped");
    wr(4'h5, 8'h00);
    wr(4'h2, 8'h03);
    wr(4'h3, 8'h01);
    foreach (rows[r]) begin
      wr(4'h0, rows[r][39:32]);
      wr(4'h1, rows[r][31:24]);
      wr(4'h4, rows[r][23:16]);
      repeat (6) @(posedge sys_clk);
      count8(cnt);
      `CHK("pin highs", rows[r][15:0], cnt)
    end
    wr(4'h6, 8'h04);
    wr(4'h0, 8'h0C);
    wr(4'h1, 8'h05);
    wr(4'h4, 8'h02);
    repeat (4) @(posedge sys_clk);
    shutdown_in <= 1'b1;
    @(posedge sys_clk);
    shutdown_in <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK("shutdown pads", 4'h7, pad)
    rd(4'h6, 8'h05, "shutdown status");
    wr(4'h6, 8'h00);
    wr(4'h2, 8'hFF);
    wr(4'h3, 8'h80);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h11);
    rd(4'h7, 8'h30, "pending");
    `CHK("held pad", 1'b0, pad[0])
    for (int i = 0; i < 600 && pad[0] !== 1'b1; i++) @(posedge sys_clk);
    rd(4'h7, 8'h21, "applied");
    wr(4'h1, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("cut pad", 1'b0, pad[0])
    end_sim;
  end
  // Whole run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    end_sim;
  end
endmodule
bind pwm_output_steering steer_asserts chk (.sys_clk, .reset_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .shutdown_in, .pwm_out_a,
  .pwm_out_b, .pwm_out_c, .pwm_out_d, .pin_oe);

// >>> tb/steer_asserts.sv
/*
  Port checker for the steering stage, shadowing register writes.
  Assumes it is bound to the top module of the stage.
*/
`timescale 1ns/1ps
module steer_asserts
  import steer_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire addr_t reg_addr,
  input wire byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire byte_t reg_rdata,
  input wire logic shutdown_in,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire pins_t pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  byte_t sh_q [8];
  logic [1:0] quiet_q;
  logic on, set, dir_wr;
  pins_t pins, fol;
  assign on = sh_q[0][3:2] == 2'h3 && sh_q[0][7:6] == 2'h0;
  assign set = quiet_q == 2'h3 && !sh_q[1][4];
  assign dir_wr = reg_write && reg_addr == 4'h5;
  assign pins = {pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a};
  assign fol = ~({4{on}} & sh_q[1][3:0]);
  ////////////////////////////////////////////////////////////////////////
  // Pins settle two edges after a write, so wait three before judging
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      quiet_q <= 2'h0;
      for (int i = 0; i < 8; i++) sh_q[i] <= (i == 1) ? 8'h01 : 8'h00;
    end else if (reg_write) begin
      quiet_q <= 2'h0;
      if (!reg_addr[3]) sh_q[reg_addr[2:0]] <= reg_wdata;
    end else if (quiet_q != 2'h3) begin
      quiet_q <= quiet_q + 2'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (
    !reg_read |=> reg_rdata == 8'h00) else $error("stray read data");
  a_steer_readback: assert property (
    reg_read && reg_addr == 4'h1 |=> reg_rdata[4:0] == sh_q[1][4:0])
    else $error("steering control readback wrong");
  a_dir_oe: assert property (
    dir_wr |-> ##[1:2] pin_oe == ~sh_q[5][3:0])
    else $error("enable does not follow direction");
  a_oe_quiet: assert property (
    !dir_wr [*2] |=> $stable(pin_oe)) else $error("enable moved alone");
  a_follow_latch: assert property (
    set |-> ((pins ^ sh_q[4][3:0]) & fol) == 4'h0)
    else $error("unsteered pin left the latch");
  a_pair_ac: assert property (
    on && set && sh_q[1][0] && sh_q[1][2] |-> pwm_out_a == pwm_out_c)
    else $error("pins A and C differ");
  a_pair_bd: assert property (
    on && set && sh_q[1][1] && sh_q[1][3] |-> pwm_out_b == pwm_out_d)
    else $error("pins B and D differ");
  a_shut_level: assert property (
    on && set && sh_q[1][0] && !sh_q[6][1] && shutdown_in
    |-> ##3 pwm_out_a == sh_q[6][2]) else $error("pin A not shut down");
  a_sync0_apply: assert property (
    on && reg_write && reg_addr == 4'h1 && reg_wdata == 8'h00
    |-> ##2 pins == sh_q[4][3:0]) else $error("steering not removed");
  c_shutdown: cover property (on && set && shutdown_in);
  c_sync_write: cover property (reg_write && reg_addr == 4'h1 && reg_wdata[4]);
  c_dir_write: cover property (dir_wr);
endmodule
